// *** dtp_defines.svh ***
/*
  Register indices, field positions and reset values of the down timer.
  Assumes inclusion by bare name from the timer design files.
*/
`ifndef DTP_DEFINES_SVH
`define DTP_DEFINES_SVH

// Register indices; byte address is four times the index
`define DTP_IDX_VALUE 4'h0
`define DTP_IDX_CTRL_A 4'h1
`define DTP_IDX_CTRL_B 4'h2
`define DTP_IDX_DUTY 4'h3
`define DTP_IDX_PSCV 4'h4
`define DTP_IDX_TONE 4'h5
`define DTP_IDX_STATUS 4'h6

// Control A fields
`define DTP_CA_RUN 0
`define DTP_CA_RELOAD 1
`define DTP_CA_ONESHOT 2
`define DTP_CA_PWM_AL 6
`define DTP_CA_PWM_EN 7

// Control B fields
`define DTP_CB_RATE_LSB 0
`define DTP_CB_PSC_N 3
`define DTP_CB_EDGE 4
`define DTP_CB_SOURCE 5

// Tone control fields
`define DTP_TONE_EN 7

// Reset values
`define DTP_RST_CTRL_A 8'h00
`define DTP_RST_CTRL_B 6'h3F
`define DTP_RST_TONE 5'h0F
`define DTP_RST_VALUE 8'hFF
`define DTP_RST_DUTY 8'h00
`define DTP_FULL 8'hFF
`define DTP_ZERO 8'h00

`endif

// *** dtp_pkg.sv ***
/*
  Types shared by the down timer design files.
  Assumes nothing of its surroundings.
*/
package dtp_pkg;
  typedef enum logic [2:0] {
    DTP_ST_IDLE = 3'b001,
    DTP_ST_RUN = 3'b010,
    DTP_ST_HALT = 3'b100
  } dtp_state_t;
endpackage

// *** dtp_presc_if.sv ***
/*
  Link between the timer core and its prescaler.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
interface dtp_presc_if;
  logic src_tick;
  logic enable_n;
  logic [2:0] rate;
  logic [7:0] count;
  logic out_tick;
  modport core_end (output src_tick, output enable_n, output rate, input count, input out_tick);
  modport presc_end (input src_tick, input enable_n, input rate, output count, output out_tick);
endinterface
`default_nettype wire

// *** dtp_prescaler.sv ***
/*
  Eight-stage prescaler with software readable count.
  Assumes one-cycle source ticks on the system clock.
*/
`timescale 1ns/10ps
`default_nettype none
module dtp_prescaler
  import dtp_pkg::*;
#(
  parameter int WIDTH = 8
)
(
  input wire logic clk_sys,
  input wire logic reset_n,
  dtp_presc_if.presc_end pif
);
  initial
  begin
    if (WIDTH != 8)
      $error("prescaler width must be 8");
  end

  logic [7:0] count_q;
  logic [7:0] mask;

  // Mask for divide by 2 up to 256
  assign mask = 8'((9'h002 << pif.rate) - 9'h001);

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      count_q <= 8'h00;
    else if (!pif.enable_n && pif.src_tick)
      count_q <= count_q + 8'h01;
  end

  assign pif.count = count_q;
  // Bypass passes every tick
  assign pif.out_tick = pif.src_tick &&
    (pif.enable_n || ((count_q & mask) == mask));

  rate_div_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (pif.out_tick && !pif.enable_n && pif.rate == 3'h0) |-> count_q[0])
    else $error("prescaler tick off its divide point");
endmodule // dtp_prescaler
`default_nettype wire

// *** dtp_down_timer.sv ***
/*
  Eight-bit down timer with prescaler, PWM and tone output on pin two.
  Assumes an APB master on CLK_SYS and an asynchronous external count pin.
*/
// The APB slave port was decided locally.
// Overview of operation
// - Free run, no reload: underflow loads 0xFF
// - Free run, reload: underflow loads reload value
// - One shot stops at underflow
// - Reload select ignored in one shot
// - Active low bit sets PWM polarity
// - PWM enable drives pin two, else tone enable, else GPIO
// - PWM active from duty match to underflow
// - Reload sets period, duty sets width
// - Duty register is write only
// - Rate codes divide by 2 to 256
// - Edge select picks falling or rising edge
// - Source select picks pin or instruction clock
// - Prescaler count readable
// - Tone codes 0-7 divide prescaler output
// - Tone codes 8-15 output timer bits
// - Value write loads reload and count
// - Underflow sets flag, software clears it
`timescale 1ns/10ps
`default_nettype none
`include "dtp_defines.svh"
module dtp_down_timer
  import dtp_pkg::*;
#(
  parameter int INST_DIV = 2
)
(
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic EXT_COUNT_INPUT,
  input wire logic GPIO_PIN_TWO_O,
  input wire logic GPIO_PIN_TWO_OE_N,
  output logic PORT_B_PIN_TWO_O,
  output logic PORT_B_PIN_TWO_OE_N,
  output logic UNDERFLOW_FLAG
);
  initial
  begin
    if (INST_DIV < 1 || INST_DIV > 256)
      $error("INST_DIV out of range");
  end

  dtp_presc_if pif ();

  logic ext_meta_q;
  logic ext_sync_q;
  logic ext_prev_q;
  logic [7:0] inst_cnt_q;
  logic inst_tick;
  logic src_tick;
  logic ext_rise;
  logic ext_fall;
  logic [7:0] value_q;
  logic [7:0] value_d;
  logic [7:0] reload_q;
  logic [7:0] duty_q;
  logic [7:0] buzz_cnt_q;
  logic run_en_q;
  logic reload_sel_q;
  logic oneshot_q;
  logic pwm_al_q;
  logic pwm_en_q;
  logic [2:0] rate_q;
  logic psc_n_q;
  logic edge_sel_q;
  logic src_sel_q;
  logic tone_en_q;
  logic [3:0] tone_rate_q;
  logic uf_flag_q;
  logic pwm_act_q;
  logic pwm_level;
  logic pin_o_q;
  logic pin_oe_n_q;
  logic [31:0] prdata_q;
  logic slverr_q;
  logic underflow;
  logic tone_lvl;
  logic wr;
  logic rd_setup;
  logic mapped;
  logic [3:0] idx;
  logic [7:0] rd_val;
  dtp_state_t state_q;
  dtp_state_t state_d;

  // Bus decode
  assign idx = PADDR[5:2];
  assign mapped = (PADDR[7:6] == 2'h0) && (PADDR[1:0] == 2'h0) &&
    (idx <= `DTP_IDX_STATUS);
  assign wr = PSEL && PENABLE && PWRITE && mapped;
  assign rd_setup = PSEL && !PENABLE && !PWRITE;
  assign PREADY = 1'b1;
  assign PRDATA = prdata_q;
  assign PSLVERR = slverr_q && PSEL && PENABLE;

  // External pin synchroniser
  always_ff @(posedge CLK_SYS)
  begin
    if (!RESET_N)
    begin
      ext_meta_q <= 1'b0;
      ext_sync_q <= 1'b0;
      ext_prev_q <= 1'b0;
    end
    else
    begin
      ext_meta_q <= EXT_COUNT_INPUT;
      ext_sync_q <= ext_meta_q;
      ext_prev_q <= ext_sync_q;
    end
  end

  assign ext_rise = ext_sync_q && !ext_prev_q;
  assign ext_fall = !ext_sync_q && ext_prev_q;

  // Instruction clock enable
  always_ff @(posedge CLK_SYS)
  begin
    if (!RESET_N)
      inst_cnt_q <= 8'h00;
    else if (inst_tick)
      inst_cnt_q <= 8'h00;
    else
      inst_cnt_q <= inst_cnt_q + 8'h01;
  end

  assign inst_tick = (inst_cnt_q == 8'(INST_DIV - 1));

  // Source and edge choice
  always_comb
  begin
    if (src_sel_q)
      src_tick = edge_sel_q ? ext_fall : ext_rise;
    else
      src_tick = inst_tick;
  end

  assign pif.src_tick = src_tick;
  assign pif.enable_n = psc_n_q;
  assign pif.rate = rate_q;

  dtp_prescaler #(
    .WIDTH(8)
  ) u_presc (
    .clk_sys(CLK_SYS),
    .reset_n(RESET_N),
    .pif(pif)
  );

  // Control registers
  always_ff @(posedge CLK_SYS)
  begin
    if (!RESET_N)
    begin
      {pwm_en_q, pwm_al_q} <= 2'h0;
      {oneshot_q, reload_sel_q, run_en_q} <= 3'h0;
      {src_sel_q, edge_sel_q, psc_n_q, rate_q} <= `DTP_RST_CTRL_B;
      {tone_en_q, tone_rate_q} <= `DTP_RST_TONE;
      duty_q <= `DTP_RST_DUTY;
    end
    else if (wr)
    begin
      case (idx)
        `DTP_IDX_CTRL_A:
        begin
          pwm_en_q <= PWDATA[`DTP_CA_PWM_EN];
          pwm_al_q <= PWDATA[`DTP_CA_PWM_AL];
          oneshot_q <= PWDATA[`DTP_CA_ONESHOT];
          reload_sel_q <= PWDATA[`DTP_CA_RELOAD];
          run_en_q <= PWDATA[`DTP_CA_RUN];
        end
        `DTP_IDX_CTRL_B:
        begin
          src_sel_q <= PWDATA[`DTP_CB_SOURCE];
          edge_sel_q <= PWDATA[`DTP_CB_EDGE];
          psc_n_q <= PWDATA[`DTP_CB_PSC_N];
          rate_q <= PWDATA[`DTP_CB_RATE_LSB +: 3];
        end
        `DTP_IDX_DUTY:
          duty_q <= PWDATA[7:0];
        `DTP_IDX_TONE:
        begin
          tone_en_q <= PWDATA[`DTP_TONE_EN];
          tone_rate_q <= PWDATA[3:0];
        end
        default:
        begin
        end
      endcase
    end
  end

  // Run state
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      DTP_ST_IDLE:
        if (run_en_q)
          state_d = DTP_ST_RUN;
      DTP_ST_RUN:
        if (!run_en_q)
          state_d = DTP_ST_IDLE;
        else if (underflow && oneshot_q)
          state_d = DTP_ST_HALT;
      DTP_ST_HALT:
        if (!run_en_q || (wr && idx == `DTP_IDX_VALUE))
          state_d = DTP_ST_IDLE;
      default:
        state_d = DTP_ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!RESET_N)
      state_q <= DTP_ST_IDLE;
    else
      state_q <= state_d;
  end

  assign underflow = (state_q == DTP_ST_RUN) && run_en_q && pif.out_tick &&
    (value_q == `DTP_ZERO);

  // Down counter
  always_comb
  begin
    value_d = value_q;
    if (wr && idx == `DTP_IDX_VALUE)
      value_d = PWDATA[7:0];
    else if (underflow)
    begin
      if (oneshot_q)
        value_d = `DTP_ZERO;
      else if (reload_sel_q)
        value_d = reload_q;
      else
        value_d = `DTP_FULL;
    end
    else if (state_q == DTP_ST_RUN && run_en_q && pif.out_tick)
      value_d = value_q - 8'h01;
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!RESET_N)
    begin
      value_q <= `DTP_RST_VALUE;
      reload_q <= `DTP_RST_VALUE;
    end
    else
    begin
      value_q <= value_d;
      if (wr && idx == `DTP_IDX_VALUE)
        reload_q <= PWDATA[7:0];
    end
  end

  // Underflow flag, set wins over clear
  always_ff @(posedge CLK_SYS)
  begin
    if (!RESET_N)
      uf_flag_q <= 1'b0;
    else if (underflow)
      uf_flag_q <= 1'b1;
    else if (wr && idx == `DTP_IDX_STATUS && PWDATA[0])
      uf_flag_q <= 1'b0;
  end

  assign UNDERFLOW_FLAG = uf_flag_q;

  // PWM active phase
  always_ff @(posedge CLK_SYS)
  begin
    if (!RESET_N)
      pwm_act_q <= 1'b0;
    else if (state_q != DTP_ST_RUN || underflow)
      pwm_act_q <= 1'b0;
    else if (value_q == duty_q)
      pwm_act_q <= 1'b1;
  end

  // Active already in the matching cycle
  assign pwm_level = pwm_act_q || (state_q == DTP_ST_RUN && value_q == duty_q);

  // Tone divider on prescaler output
  always_ff @(posedge CLK_SYS)
  begin
    if (!RESET_N)
      buzz_cnt_q <= 8'h00;
    else if (pif.out_tick)
      buzz_cnt_q <= buzz_cnt_q + 8'h01;
  end

  assign tone_lvl = tone_rate_q[3] ? value_q[tone_rate_q[2:0]]
    : buzz_cnt_q[tone_rate_q[2:0]];

  // Pin two drive
  always_ff @(posedge CLK_SYS)
  begin
    if (!RESET_N)
    begin
      pin_o_q <= 1'b0;
      pin_oe_n_q <= 1'b1;
    end
    else if (pwm_en_q)
    begin
      pin_o_q <= pwm_level ^ pwm_al_q;
      pin_oe_n_q <= 1'b0;
    end
    else if (tone_en_q)
    begin
      pin_o_q <= tone_lvl;
      pin_oe_n_q <= 1'b0;
    end
    else
    begin
      pin_o_q <= GPIO_PIN_TWO_O;
      pin_oe_n_q <= GPIO_PIN_TWO_OE_N;
    end
  end

  assign PORT_B_PIN_TWO_O = pin_o_q;
  assign PORT_B_PIN_TWO_OE_N = pin_oe_n_q;

  // Read data, captured in the setup cycle
  always_comb
  begin
    case (idx)
      `DTP_IDX_VALUE: rd_val = value_q;
      `DTP_IDX_CTRL_A: rd_val = {5'h00, oneshot_q, reload_sel_q, run_en_q};
      `DTP_IDX_CTRL_B: rd_val = {2'h0, src_sel_q, edge_sel_q, psc_n_q, rate_q};
      `DTP_IDX_PSCV: rd_val = pif.count;
      `DTP_IDX_STATUS: rd_val = {7'h00, uf_flag_q};
      default: rd_val = 8'h00;
    endcase
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!RESET_N)
    begin
      prdata_q <= 32'h0000_0000;
      slverr_q <= 1'b0;
    end
    else if (PSEL && !PENABLE)
    begin
      prdata_q <= (rd_setup && mapped) ? {24'h00_0000, rd_val} : 32'h0000_0000;
      slverr_q <= !mapped;
    end
  end

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RESET_N);

  hold_stopped_a: assert property (
    (!run_en_q && !(wr && idx == `DTP_IDX_VALUE)) |=> $stable(value_q))
    else $error("count moved while stopped");
  reload_full_a: assert property (
    (underflow && !oneshot_q && !reload_sel_q && !wr) |=> value_q == 8'hFF)
    else $error("free run did not load 0xFF");
  reload_value_a: assert property (
    (underflow && !oneshot_q && reload_sel_q && !wr) |=> value_q == $past(reload_q))
    else $error("free run did not load reload");
  oneshot_halt_a: assert property (
    (underflow && oneshot_q && !wr) |=> (state_q == DTP_ST_HALT && value_q == 8'h00) ##1
    (value_q == 8'h00 || $past(wr)))
    else $error("one shot did not stop");
  pwm_pin_a: assert property (
    pwm_en_q |=> !PORT_B_PIN_TWO_OE_N && PORT_B_PIN_TWO_O == $past(pwm_level ^ pwm_al_q))
    else $error("pwm level wrong on pin");
  pwm_clear_a: assert property (
    underflow |=> !pwm_act_q)
    else $error("pwm still active after underflow");
  duty_read_a: assert property (
    (rd_setup && idx == `DTP_IDX_DUTY) |=> prdata_q == 32'h0000_0000)
    else $error("duty register readable");
  value_write_a: assert property (
    (wr && idx == `DTP_IDX_VALUE) |=> value_q == $past(PWDATA[7:0]) &&
    reload_q == $past(PWDATA[7:0]))
    else $error("value write not taken");
  flag_set_a: assert property (
    underflow |=> uf_flag_q ##1
    (uf_flag_q || $past(wr && idx == `DTP_IDX_STATUS && PWDATA[0])))
    else $error("underflow flag lost");
  tone_bit_a: assert property (
    (tone_en_q && !pwm_en_q && tone_rate_q[3]) |=>
    PORT_B_PIN_TWO_O == $past(value_q[tone_rate_q[2:0]]))
    else $error("tone timer bit wrong");
  ext_edge_a: assert property (
    (src_sel_q && edge_sel_q && $fell(ext_sync_q)) |-> src_tick)
    else $error("falling edge missed");

  reload_run_c: cover property (underflow && reload_sel_q && !oneshot_q);
  oneshot_end_c: cover property (state_q == DTP_ST_RUN ##1 state_q == DTP_ST_HALT);
  pwm_active_c: cover property (pwm_en_q && $rose(pwm_act_q));
  tone_out_c: cover property (tone_en_q && !tone_rate_q[3] && $rose(PORT_B_PIN_TWO_O));
endmodule // dtp_down_timer
`default_nettype wire

// *** dtp_pin_partner.sv ***
/*
  Far side of the timer: count pin driver and pin two load.
  Assumes the bench sets the count pin level between edges.
*/
`timescale 1ns/10ps
`default_nettype none
module dtp_pin_partner
(
  input wire logic clk,
  input wire logic ext_level,
  input wire logic pin_o,
  input wire logic pin_oe_n,
  output logic ext_pin = 1'b0,
  output logic pad
);
  // Count pin moves only when commanded
  always_ff @(posedge clk)
    ext_pin <= ext_level;
  // Load with pull-down when pin released
  assign pad = pin_oe_n ? 1'b0 : pin_o;
endmodule // dtp_pin_partner
`default_nettype wire

// *** test_down_timer_pwm_buzzer.sv ***
/*
  Directed bench for the down timer over APB.
  Assumes the pin partner and design files are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module test_down_timer_pwm_buzzer;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] padr = 8'h00;
  logic [31:0] pwd = 32'h00000000;
  logic [31:0] prd;
  logic prdy, perr, ext, pin_o, pin_oe_n, flag, pad, e;
  logic ext_lvl = 1'b0;
  logic gp_o = 1'b0;
  logic gp_oe_n = 1'b1;
  logic [7:0] q, q2;
  int fails = 0;
  int compares = 0;
  int cyc = 0;
  int t0, n;

  always #4 clk = ~clk;

  dtp_down_timer #(.INST_DIV(1)) i_dut (.CLK_SYS(clk), .RESET_N(rst_n), .PSEL(psel),
    .PENABLE(pen), .PWRITE(pwr), .PADDR(padr), .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy),
    .PSLVERR(perr), .EXT_COUNT_INPUT(ext), .GPIO_PIN_TWO_O(gp_o),
    .GPIO_PIN_TWO_OE_N(gp_oe_n), .PORT_B_PIN_TWO_O(pin_o),
    .PORT_B_PIN_TWO_OE_N(pin_oe_n), .UNDERFLOW_FLAG(flag));

  dtp_pin_partner i_far (.clk(clk), .ext_level(ext_lvl), .pin_o(pin_o),
    .pin_oe_n(pin_oe_n), .ext_pin(ext), .pad(pad));

  task automatic complete_run;
    $display("Counts: compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      fails++;
      complete_run;
    end
  end

  task automatic apb(input logic w, input logic [3:0] idx, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    padr <= {2'h0, idx, 2'h0};
    pwd <= {24'h000000, d};
    @(posedge clk);
    pen <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (prdy !== 1'b1);
    q = prd[7:0];
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rdc(input logic [3:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk({8'h00, q}, {8'h00, exp});
  endtask

  task automatic hi(input int m);
    n = 0;
    repeat (m)
    begin
      @(posedge clk);
      if (pad === 1'b1)
        n++;
    end
  endtask

  task automatic wflag;
    while (flag !== 1'b1)
    begin
      @(posedge clk);
    end
  endtask

  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rdc(4'h0, 8'hFF);
    rdc(4'h1, 8'h00);
    rdc(4'h2, 8'h3F);
    rdc(4'h6, 8'h00);
    apb(1'b0, 4'h7, 8'h00);
    chk({15'h0000, e}, 16'h0001);
    chk({8'h00, q}, 16'h0000);
    $display("test reset done");
    apb(1'b1, 4'h0, 8'h40);
    rdc(4'h0, 8'h40);
    apb(1'b1, 4'h3, 8'h55);
    rdc(4'h3, 8'h00);
    rdc(4'h0, 8'h40);
    $display("test access done");
    apb(1'b1, 4'h2, 8'h08);
    apb(1'b1, 4'h0, 8'h05);
    apb(1'b1, 4'h1, 8'h07);
    repeat (20) @(posedge clk);
    rdc(4'h0, 8'h00);
    chk({15'h0000, flag}, 16'h0001);
    rdc(4'h6, 8'h01);
    apb(1'b1, 4'h6, 8'h01);
    rdc(4'h6, 8'h00);
    $display("test one shot done");
    apb(1'b1, 4'h1, 8'h00);
    apb(1'b1, 4'h0, 8'h40);
    apb(1'b1, 4'h1, 8'h01);
    wflag;
    apb(1'b0, 4'h0, 8'h00);
    chk({15'h0000, q > 8'hF0}, 16'h0001);
    apb(1'b1, 4'h1, 8'h00);
    apb(1'b1, 4'h6, 8'h01);
    apb(1'b1, 4'h0, 8'h40);
    apb(1'b1, 4'h1, 8'h03);
    wflag;
    apb(1'b0, 4'h0, 8'h00);
    chk({15'h0000, q > 8'h38 && q <= 8'h40}, 16'h0001);
    apb(1'b1, 4'h1, 8'h02);
    apb(1'b0, 4'h0, 8'h00);
    q2 = q;
    repeat (10) @(posedge clk);
    rdc(4'h0, q2);
    $display("test free run done");
    for (int r = 0; r < 8; r++)
    begin
      apb(1'b1, 4'h1, 8'h00);
      apb(1'b1, 4'h2, 8'h08 | 8'(r));
      apb(1'b1, 4'h2, 8'(r));
      apb(1'b1, 4'h0, 8'h04);
      apb(1'b1, 4'h6, 8'h01);
      apb(1'b1, 4'h1, 8'h03);
      wflag;
      t0 = cyc;
      apb(1'b1, 4'h6, 8'h01);
      @(posedge clk);
      wflag;
      chk(16'(cyc - t0), 16'(5 * (2 << r)));
      if (r < 7)
        apb(1'b1, 4'h2, 8'h08 | 8'(r));
    end
    apb(1'b0, 4'h4, 8'h00);
    q2 = q;
    apb(1'b0, 4'h4, 8'h00);
    chk({8'h00, q - q2}, 16'h0003);
    $display("test prescaler done");
    apb(1'b1, 4'h2, 8'h0F);
    apb(1'b1, 4'h2, 8'h08);
    apb(1'b1, 4'h0, 8'h09);
    apb(1'b1, 4'h3, 8'h02);
    apb(1'b1, 4'h1, 8'h83);
    repeat (30) @(posedge clk);
    hi(100);
    chk(16'(n), 16'h001E);
    chk({15'h0000, pin_oe_n}, 16'h0000);
    apb(1'b1, 4'h1, 8'hC3);
    repeat (30) @(posedge clk);
    hi(100);
    chk(16'(n), 16'h0046);
    apb(1'b1, 4'h1, 8'h03);
    gp_o <= 1'b1;
    gp_oe_n <= 1'b0;
    repeat (3) @(posedge clk);
    chk({15'h0000, pad}, 16'h0001);
    gp_oe_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk({15'h0000, pin_oe_n}, 16'h0001);
    $display("test pwm done");
    apb(1'b1, 4'h0, 8'hFF);
    for (int c = 0; c < 16; c++)
    begin
      apb(1'b1, 4'h5, 8'h80 | 8'(c));
      repeat (8) @(posedge clk);
      hi(512);
      chk(16'(n), 16'h0100);
    end
    apb(1'b1, 4'h0, 8'h09);
    apb(1'b1, 4'h5, 8'h89);
    repeat (20) @(posedge clk);
    hi(100);
    chk(16'(n), 16'h0028);
    $display("test tone done");
    apb(1'b1, 4'h5, 8'h00);
    apb(1'b1, 4'h1, 8'h00);
    apb(1'b1, 4'h2, 8'h38);
    apb(1'b1, 4'h0, 8'h10);
    apb(1'b1, 4'h1, 8'h01);
    ext_lvl <= 1'b1;
    repeat (8) @(posedge clk);
    rdc(4'h0, 8'h10);
    ext_lvl <= 1'b0;
    repeat (8) @(posedge clk);
    rdc(4'h0, 8'h0F);
    apb(1'b1, 4'h2, 8'h28);
    ext_lvl <= 1'b1;
    repeat (8) @(posedge clk);
    rdc(4'h0, 8'h0E);
    ext_lvl <= 1'b0;
    repeat (8) @(posedge clk);
    rdc(4'h0, 8'h0E);
    $display("test count pin done");
    complete_run;
  end
endmodule // test_down_timer_pwm_buzzer
`default_nettype wire
